// ===== core/gicas_edge_latch.sv
// Per-pin rising-edge detector with sticky raw status bits.
// Assumes pin levels are already synchronous to clock.
`timescale 1ns/1ps
module gicas_edge_latch #(
    parameter int LINES = gicas_pkg::LINE_COUNT
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Pin levels and clear pulse
    input  wire logic [7:0] pinLevel,
    input  wire logic [7:0] clearBits,
    // Latched status
    output logic      [7:0] rawStatus
);

    // Lines above LINES are masked off by the caller; the latch itself is always 8 wide
    generate
        if (LINES < 1 || LINES > gicas_pkg::LINE_COUNT) begin : g_bad_lines
            $error("gicas_edge_latch: LINES must be 1 to 8");
        end
    endgenerate

    gicas_pkg::gicas_latch_state_t state_reg;
    gicas_pkg::gicas_latch_state_t state_next;
    logic                    [7:0] riseBits;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_rise
            assign riseBits[i] = pinLevel[i] & ~state_reg.pinPrev[i];
        end
    endgenerate

    // An edge in the same cycle as its clear survives
    always_comb begin
        state_next         = state_reg;
        state_next.pinPrev = pinLevel;
        state_next.raw     = (state_reg.raw & ~clearBits) | riseBits;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg.pinPrev <= gicas_pkg::PIN_PREV_RESET;
            state_reg.raw     <= gicas_pkg::RAW_STATUS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rawStatus = state_reg.raw;

    clear_effect_a: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> (rawStatus & $past(clearBits) & ~$past(riseBits)) == 8'h00)
        else $error("cleared latch bit still set");

    zero_keeps_a: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> ($past(rawStatus) & ~$past(clearBits) & ~rawStatus) == 8'h00)
        else $error("latch bit lost without a clear");

    raw_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (riseBits != 8'h00) |=> (($past(riseBits) & ~rawStatus) == 8'h00))
        else $error("detected edge not latched");

endmodule : gicas_edge_latch

// ===== core/gicas_pkg.sv
// Constants, register map and carrier types for one GPIO port slice.
// Assumes a single 40 MHz clock and a plain strobe register port.
package gicas_pkg;

    localparam int          LINE_COUNT  = 8;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          FIELD_LSB   = 0;
    localparam int          FIELD_MSB   = 7;

    localparam logic [11:0] OFF_LINE_DIRECTION       = 12'h400;
    localparam logic [11:0] OFF_RAW_IRQ_STATUS       = 12'h414;
    localparam logic [11:0] OFF_IRQ_EDGE_CLEAR       = 12'h41C;
    localparam logic [11:0] OFF_LINE_FUNCTION_SELECT = 12'h420;

    localparam logic [7:0]  DIRECTION_RESET     = 8'h00;
    localparam logic [7:0]  RAW_STATUS_RESET    = 8'h00;
    localparam logic [7:0]  PIN_PREV_RESET      = 8'h00;
    localparam logic [7:0]  SELECT_RESET_PLAIN  = 8'h00;
    localparam logic [7:0]  SELECT_RESET_PORT_B = 8'h80;
    localparam logic [7:0]  SELECT_RESET_PORT_C = 8'h0F;
    localparam logic [31:0] READ_ZERO           = 32'h00000000;

    typedef struct packed {
        logic        wrStrobe;
        logic        rdStrobe;
        logic [11:0] addr;
        logic [31:0] wrData;
    } gicas_bus_req_t;

    typedef struct packed {
        logic [7:0]  direction;
        logic [7:0]  funcSelect;
        logic [31:0] rdData;
    } gicas_port_state_t;

    typedef struct packed {
        logic [7:0] pinPrev;
        logic [7:0] raw;
    } gicas_latch_state_t;

endpackage : gicas_pkg

// ===== core/gicas_port.sv
// Interrupt clear and function select registers for one GPIO port.
// Assumes a register master with one-cycle strobes and no wait states.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module gicas_port #(
    parameter int         LINES        = gicas_pkg::LINE_COUNT,
    parameter logic [7:0] SELECT_RESET = gicas_pkg::SELECT_RESET_PORT_B
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Register port
    input  wire gicas_pkg::gicas_bus_req_t busReq,
    output logic                    [31:0] rdData,
    // Pin side
    input  wire logic                [7:0] pinIn,
    output logic                     [7:0] lineDirection,
    output logic                     [7:0] lineFunctionSelect,
    output logic                     [7:0] rawIrqStatus
);

    localparam int         MASK_INT  = (1 << LINES) - 1;
    localparam logic [7:0] LINE_MASK = 8'(MASK_INT);

    generate
        if (LINES < 1 || LINES > gicas_pkg::LINE_COUNT) begin : g_bad_lines
            $error("gicas_port: LINES must be 1 to 8");
        end
    endgenerate

    gicas_pkg::gicas_port_state_t state_reg;
    gicas_pkg::gicas_port_state_t state_next;

    logic       hitDirection;
    logic       hitRawStatus;
    logic       hitClear;
    logic       hitSelect;
    logic [7:0] wrField;
    logic [7:0] clearBits;
    logic [7:0] rawStatus;

    assign hitDirection = busReq.addr == gicas_pkg::OFF_LINE_DIRECTION;
    assign hitRawStatus = busReq.addr == gicas_pkg::OFF_RAW_IRQ_STATUS;
    assign hitClear     = busReq.addr == gicas_pkg::OFF_IRQ_EDGE_CLEAR;
    assign hitSelect    = busReq.addr == gicas_pkg::OFF_LINE_FUNCTION_SELECT;

    // Bits above the field are dropped on write
    assign wrField = busReq.wrData[gicas_pkg::FIELD_MSB:gicas_pkg::FIELD_LSB] & LINE_MASK;

    // Clear is a pulse, acting on the edge that ends the write
    assign clearBits = (busReq.wrStrobe && hitClear) ? wrField : 8'h00;

    gicas_edge_latch #(
        .LINES (LINES)
    ) u_edge_latch (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .pinLevel  (pinIn & LINE_MASK),
        .clearBits (clearBits),
        .rawStatus (rawStatus)
    );

    always_comb begin
        state_next        = state_reg;
        state_next.rdData = gicas_pkg::READ_ZERO;
        if (busReq.wrStrobe) begin
            if (hitDirection) begin
                state_next.direction = wrField;
            end
            if (hitSelect) begin
                state_next.funcSelect = wrField;
            end
        end
        // Unmapped reads and the clear register answer zero
        if (busReq.rdStrobe) begin
            case (1'b1)
                hitDirection: begin
                    state_next.rdData = {24'h000000, state_reg.direction};
                end
                hitRawStatus: begin
                    state_next.rdData = {24'h000000, rawStatus};
                end
                hitSelect: begin
                    state_next.rdData = {24'h000000, state_reg.funcSelect};
                end
                default: begin
                    state_next.rdData = gicas_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // One reset serves both power-on and the external pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg.direction  <= gicas_pkg::DIRECTION_RESET;
            state_reg.funcSelect <= SELECT_RESET & LINE_MASK;
            state_reg.rdData     <= gicas_pkg::READ_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdData             = state_reg.rdData;
    assign lineDirection      = state_reg.direction;
    assign lineFunctionSelect = state_reg.funcSelect;
    assign rawIrqStatus       = rawStatus;

    reset_select_a: assert property (@(posedge clock)
        sys_rst |=> lineFunctionSelect == (SELECT_RESET & LINE_MASK))
        else $error("function select wrong after reset");

    reset_direction_a: assert property (@(posedge clock)
        sys_rst |=> lineDirection == gicas_pkg::DIRECTION_RESET)
        else $error("direction wrong after reset");

    select_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (busReq.wrStrobe && hitSelect)
            |=> lineFunctionSelect == ($past(busReq.wrData[7:0]) & LINE_MASK))
        else $error("function select write not taken");

    select_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !(busReq.wrStrobe && hitSelect) |=> $stable(lineFunctionSelect))
        else $error("function select changed without a write");

    clear_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (busReq.rdStrobe && hitClear) |=> rdData == gicas_pkg::READ_ZERO)
        else $error("clear register read not zero");

    upper_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        busReq.rdStrobe |=> rdData[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    raw_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (busReq.rdStrobe && hitRawStatus) |=> rdData[7:0] == $past(rawIrqStatus))
        else $error("raw status read mismatch");

    select_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (busReq.rdStrobe && hitSelect) |=> rdData[7:0] == $past(lineFunctionSelect))
        else $error("function select read mismatch");

endmodule : gicas_port

// ===== tb/gicas_port_tb.sv
// Self-checking bench for the GPIO port slice: edge clear and function select.
// Assumes the register port answers reads one cycle later and never waits.
`timescale 1ns/1ps
module gicas_port_tb;
    logic                      clock  = 1'b0;
    logic                      sysRst = 1'b1;
    gicas_pkg::gicas_bus_req_t busReq = '0;
    logic               [31:0] rdData;
    // Port B line 7 sits high through every reset, so it is never pulled low there
    logic                [7:0] pinIn  = 8'h80;
    logic                [7:0] lineDirection;
    logic                [7:0] lineFunctionSelect;
    logic                [7:0] rawIrqStatus;
    int                        errors = 0;
    int                        nTests = 0;
    int                        seed   = 32'hF430;
    logic               [31:0] d;
    logic                [7:0] p;
    logic                [7:0] c;

    always #12.5 clock = ~clock;

    gicas_port DUT (
        .clock              (clock),
        .sys_rst            (sysRst),
        .busReq             (busReq),
        .rdData             (rdData),
        .pinIn              (pinIn),
        .lineDirection      (lineDirection),
        .lineFunctionSelect (lineFunctionSelect),
        .rawIrqStatus       (rawIrqStatus)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Called in the time step of a rising edge; the release gets an edge of its own,
    // so a following call never assigns the bus twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        busReq <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: v};
        @(posedge clock);
        busReq <= '0;
        @(posedge clock);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        busReq <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: 32'h0};
        @(posedge clock);
        busReq <= '0;
        @(negedge clock);
        chk(rdData, exp, "read data");
        @(posedge clock);
    endtask : rd

    // Entered at the last edge with reset high; a pin held high shows as an edge next cycle
    task automatic chk_defaults(input logic [7:0] held);
        @(negedge clock);
        chk({24'h0, lineFunctionSelect}, 32'h80, "select reset");
        chk({24'h0, lineDirection}, 32'h0, "direction reset");
        chk({24'h0, rawIrqStatus}, 32'h0, "status reset");
        @(negedge clock);
        chk({24'h0, rawIrqStatus}, {24'h0, held}, "edge after reset");
        @(posedge clock);
        rd(12'h420, 32'h00000080);
    endtask : chk_defaults

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clock);
        sysRst <= 1'b0;
        chk_defaults(8'h80);
        $display("test reset done");
        // All-zero and all-one fields first, then random words
        for (int k = 0; k < 12; k++) begin
            d = (k < 2) ? {32{k[0]}} : $random(seed);
            wr(12'h420, d);
            chk({24'h0, lineFunctionSelect}, {24'h0, d[7:0]}, "select out");
            rd(12'h420, {24'h0, d[7:0]});
            wr(12'h400, ~d);
            chk({24'h0, lineDirection}, {24'h0, ~d[7:0]}, "direction out");
            rd(12'h400, {24'h0, ~d[7:0]});
            wr(12'h7F0, 32'hFFFFFFFF);
            rd(12'h7F0, 32'h0);
            chk({24'h0, lineFunctionSelect}, {24'h0, d[7:0]}, "select kept");
        end
        // Software hands the debug lines back before moving on
        wr(12'h420, 32'h00000080);
        chk({24'h0, lineFunctionSelect}, 32'h80, "debug restored");
        $display("test select done");
        for (int k = 0; k < 12; k++) begin
            p = (k == 0) ? 8'hFF : 8'($random(seed));
            c = (k == 1) ? 8'h00 : 8'($random(seed));
            pinIn <= 8'h00;
            wr(12'h41C, 32'h000000FF);
            chk({24'h0, rawIrqStatus}, 32'h0, "cleared");
            pinIn <= p;
            @(posedge clock);
            @(negedge clock);
            chk({24'h0, rawIrqStatus}, {24'h0, p}, "edge latched");
            @(posedge clock);
            d = $random(seed);
            wr(12'h41C, {d[31:8], c});
            chk({24'h0, rawIrqStatus}, {24'h0, p & ~c}, "clear mask");
            rd(12'h414, {24'h0, p & ~c});
            rd(12'h41C, 32'h0);
        end
        // Edge and clear in one cycle: the edge wins
        pinIn <= 8'h00;
        wr(12'h41C, 32'h000000FF);
        pinIn <= 8'h3C;
        wr(12'h41C, 32'h000000FF);
        chk({24'h0, rawIrqStatus}, 32'h3C, "edge beats clear");
        $display("test clear done");
        wr(12'h420, 32'h0000005A);
        wr(12'h400, 32'h000000FF);
        chk({24'h0, lineFunctionSelect}, 32'h5A, "select before reset");
        pinIn <= 8'hC3;
        sysRst <= 1'b1;
        @(posedge clock);
        sysRst <= 1'b0;
        chk_defaults(8'hC3);
        $display("test second reset done");
        print_verdict();
    end
endmodule : gicas_port_tb
